// ===== inc/ftc_defines.vh
`ifndef FTC_DEFINES_VH
`define FTC_DEFINES_VH

// Register offsets, one byte each on the register port
`define FTC_OFS_CONFIG 8'h00
`define FTC_OFS_TACH1 8'h01
`define FTC_OFS_TACH2 8'h02
`define FTC_OFS_PRELOAD1 8'h03
`define FTC_OFS_PRELOAD2 8'h04
`define FTC_OFS_SPEED1 8'h05
`define FTC_OFS_SPEED2 8'h06
`define FTC_OFS_STATUS 8'h07

// Clock configuration fields
`define FTC_CFG_BASE1_BIT 0
`define FTC_CFG_BASE2_BIT 1
`define FTC_CFG_MULT1_BIT 2
`define FTC_CFG_MULT2_BIT 3
`define FTC_CFG_DIV1_LSB 4
`define FTC_CFG_DIV2_LSB 6
`define FTC_CFG_RESET 8'h50

// Speed select register: only the base clock bit is kept here
`define FTC_SPD_BASE_BIT 7
`define FTC_SPD_MASK 8'h80
`define FTC_SPD_RESET 8'h00

`define FTC_PRELOAD_RESET 8'h00
`define FTC_TACH_RESET 8'h00

// Status fields: two bits each, bit n belongs to fan n+1
`define FTC_STS_VALID_LSB 0
`define FTC_STS_FRESH_LSB 2
`define FTC_STS_STALL_LSB 4

// Pulses to discard after a preload write
`define FTC_SKIP_PULSES 2'd2

// Timing: system clock period and base count clock periods
`define FTC_CLK_NS 50
`define FTC_BASE0_NS 3200
`define FTC_BASE1_NS 6400
`define FTC_BASE2_NS 12800
`define FTC_BASE3_NS 25600
`define FTC_NS_TO_CYC(t) (((t) + `FTC_CLK_NS - 1) / `FTC_CLK_NS)

`endif

// ===== design/ftc_count_core.v
module ftc_count_core #(
  parameter CW = 8
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire pulse_edge_i,
  input wire tick_i,
  input wire [CW-1:0] preload_i,
  output wire [CW-1:0] count_o,
  output wire sat_o
);

  localparam [CW-1:0] CNT_MAX = {CW{1'b1}};

  reg [CW-1:0] run_q;
  reg [CW-1:0] run_d;
  reg [CW-1:0] latch_q;
  reg [CW-1:0] latch_d;

  always @* begin
    run_d = run_q;
    if (pulse_edge_i) begin
      run_d = preload_i;
    end else if (tick_i && (run_q != CNT_MAX)) begin
      run_d = run_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always @* begin
    latch_d = latch_q;
    if (pulse_edge_i) begin
      latch_d = run_q;
    end else if (run_q == CNT_MAX) begin
      // Stalled fan shows full scale without waiting for an edge
      latch_d = CNT_MAX;
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      run_q <= {CW{1'b0}};
      latch_q <= {CW{1'b0}};
    end else begin
      run_q <= run_d;
      latch_q <= latch_d;
    end
  end

  assign count_o = latch_q;
  assign sat_o = (run_q == CNT_MAX);

endmodule

// ===== design/ftc_top.v
// Functional notes
// - Config bit 2 set doubles the fan one count clock chosen by config bit 0 and its speed bit 7.
// - Config bit 3 set doubles the fan two count clock chosen by config bit 1 and its speed bit 7.
// - Config bits 5:4 divide the fan one count clock by 1, 2, 4 or 8, resetting to divide by 2.
// - Config bits 7:6 divide the fan two count clock by 1, 2, 4 or 8, resetting to divide by 2.
// - Fan one counts scaled clock ticks per tach pulse into an 8-bit read-only value.
// - Fan two keeps its own 8-bit count using its own divisor and multiplier.
// - Each pulse end latches the final count, held until the next pulse ends or the count saturates.
// - After a preload write the reading is flagged invalid for two pulses.
// - The fan one tach register clears to zero at standby supply power-on reset.
//
// Strobed register access and the register offsets are this design's own decisions.
`include "ftc_defines.vh"

module ftc_top #(
  parameter NFAN = 2,
  parameter CW = 8,
  parameter PW = 16
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [7:0] bus_addr_i,
  input wire [7:0] bus_wdata_i,
  input wire bus_wr_i,
  input wire bus_rd_i,
  output wire [7:0] bus_rdata_o,
  input wire fan_one_tach_i,
  input wire fan_two_tach_i,
  output wire [1:0] fan_count_valid_o
);

  localparam [31:0] BASE0_N = `FTC_NS_TO_CYC(`FTC_BASE0_NS);
  localparam [31:0] BASE1_N = `FTC_NS_TO_CYC(`FTC_BASE1_NS);
  localparam [31:0] BASE2_N = `FTC_NS_TO_CYC(`FTC_BASE2_NS);
  localparam [31:0] BASE3_N = `FTC_NS_TO_CYC(`FTC_BASE3_NS);
  // Cut to prescaler width; the slowest base with divide by 8 still fits
  localparam [PW-1:0] BASE0_CYC = BASE0_N[PW-1:0];
  localparam [PW-1:0] BASE1_CYC = BASE1_N[PW-1:0];
  localparam [PW-1:0] BASE2_CYC = BASE2_N[PW-1:0];
  localparam [PW-1:0] BASE3_CYC = BASE3_N[PW-1:0];

  // Register file
  reg [7:0] cfg_q;
  reg [7:0] cfg_d;
  reg [15:0] preload_q;
  reg [15:0] preload_d;
  reg [7:0] speed1_q;
  reg [7:0] speed2_q;
  reg [7:0] speed1_d;
  reg [7:0] speed2_d;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;

  wire [1:0] tach_raw_w;
  wire [1:0] sat_w;
  wire [1:0] valid_w;
  wire [1:0] fresh_w;
  wire [1:0] stall_w;
  wire [15:0] tach_w;
  wire [1:0] preload_wr_w;
  wire [1:0] tach_rd_w;
  wire [1:0] stall_clr_w;
  wire [7:0] status_w;

  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    input strobe;
    begin
      hit = strobe && (addr == ofs);
    end
  endfunction

  // Divisor code to shift amount: 00..11 gives divide by 1, 2, 4, 8
  function [1:0] div_shift;
    input [1:0] code;
    begin
      case (code)
        2'b00: div_shift = 2'd0;
        2'b01: div_shift = 2'd1;
        2'b10: div_shift = 2'd2;
        2'b11: div_shift = 2'd3;
        default: div_shift = 2'd1;
      endcase
    end
  endfunction

  // Count clock period in system cycles
  function [PW-1:0] tick_period;
    input [1:0] base_sel;
    input mult;
    input [1:0] div_code;
    reg [PW-1:0] base;
    reg [PW-1:0] scaled;
    begin
      case (base_sel)
        2'b00: base = BASE0_CYC;
        2'b01: base = BASE1_CYC;
        2'b10: base = BASE2_CYC;
        2'b11: base = BASE3_CYC;
        default: base = BASE0_CYC;
      endcase
      // Doubling the rate halves the period
      scaled = mult ? (base >> 1) : base;
      scaled = scaled << div_shift(div_code);
      tick_period = (scaled == {PW{1'b0}}) ? {{(PW-1){1'b0}}, 1'b1} : scaled;
    end
  endfunction

  assign tach_raw_w = {fan_two_tach_i, fan_one_tach_i};

  assign preload_wr_w[0] = hit(bus_addr_i, `FTC_OFS_PRELOAD1, bus_wr_i);
  assign preload_wr_w[1] = hit(bus_addr_i, `FTC_OFS_PRELOAD2, bus_wr_i);
  assign tach_rd_w[0] = hit(bus_addr_i, `FTC_OFS_TACH1, bus_rd_i);
  assign tach_rd_w[1] = hit(bus_addr_i, `FTC_OFS_TACH2, bus_rd_i);
  assign stall_clr_w = hit(bus_addr_i, `FTC_OFS_STATUS, bus_wr_i) ?
                       bus_wdata_i[`FTC_STS_STALL_LSB +: 2] : 2'b00;

  always @* begin
    cfg_d = cfg_q;
    preload_d = preload_q;
    speed1_d = speed1_q;
    speed2_d = speed2_q;
    if (hit(bus_addr_i, `FTC_OFS_CONFIG, bus_wr_i)) begin
      cfg_d = bus_wdata_i;
    end
    if (preload_wr_w[0]) begin
      preload_d[7:0] = bus_wdata_i;
    end
    if (preload_wr_w[1]) begin
      preload_d[15:8] = bus_wdata_i;
    end
    if (hit(bus_addr_i, `FTC_OFS_SPEED1, bus_wr_i)) begin
      speed1_d = bus_wdata_i & `FTC_SPD_MASK;
    end
    if (hit(bus_addr_i, `FTC_OFS_SPEED2, bus_wr_i)) begin
      speed2_d = bus_wdata_i & `FTC_SPD_MASK;
    end
  end

  assign status_w = {2'b00, stall_w, fresh_w, valid_w};

  // Read data live only in the cycle after the strobe
  always @* begin
    rdata_d = 8'h00;
    if (bus_rd_i) begin
      case (bus_addr_i)
        `FTC_OFS_CONFIG: rdata_d = cfg_q;
        `FTC_OFS_TACH1: rdata_d = tach_w[7:0];
        `FTC_OFS_TACH2: rdata_d = tach_w[15:8];
        `FTC_OFS_PRELOAD1: rdata_d = preload_q[7:0];
        `FTC_OFS_PRELOAD2: rdata_d = preload_q[15:8];
        `FTC_OFS_SPEED1: rdata_d = speed1_q;
        `FTC_OFS_SPEED2: rdata_d = speed2_q;
        `FTC_OFS_STATUS: rdata_d = status_w;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_q <= `FTC_CFG_RESET;
      preload_q <= {2{`FTC_PRELOAD_RESET}};
      speed1_q <= `FTC_SPD_RESET;
      speed2_q <= `FTC_SPD_RESET;
      rdata_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      preload_q <= preload_d;
      speed1_q <= speed1_d;
      speed2_q <= speed2_d;
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata_o = rdata_q;
  assign fan_count_valid_o = valid_w;

  genvar ch;
  generate
    for (ch = 0; ch < NFAN; ch = ch + 1) begin : g_ch
      reg [2:0] sync_q;
      reg level_q;
      reg level_d;
      reg [PW-1:0] presc_q;
      reg [PW-1:0] presc_d;
      reg [1:0] skip_q;
      reg [1:0] skip_d;
      reg fresh_q;
      reg stall_q;
      reg valid_q;
      wire [1:0] base_sel;
      wire mult;
      wire [1:0] div_code;
      wire [PW-1:0] period;
      wire tick;
      wire pulse_edge;

      // Per-fan clock selection; each fan reads only its own fields
      assign base_sel = {cfg_q[`FTC_CFG_BASE1_BIT + ch],
                         (ch == 0) ? speed1_q[`FTC_SPD_BASE_BIT] :
                                     speed2_q[`FTC_SPD_BASE_BIT]};
      assign mult = cfg_q[`FTC_CFG_MULT1_BIT + ch];
      assign div_code = cfg_q[`FTC_CFG_DIV1_LSB + 2*ch +: 2];
      assign period = tick_period(base_sel, mult, div_code);

      // Level moves only when the two later stages agree
      always @* begin
        level_d = level_q;
        if (sync_q[1] == sync_q[2]) begin
          level_d = sync_q[2];
        end
      end

      assign pulse_edge = level_d && !level_q;

      always @(posedge clk_sys_i) begin
        if (rst_i) begin
          sync_q <= 3'b000;
          level_q <= 1'b0;
        end else begin
          sync_q <= {sync_q[1:0], tach_raw_w[ch]};
          level_q <= level_d;
        end
      end

      // Prescaler restarts with the pulse so every period starts aligned
      assign tick = (presc_q >= period - {{(PW-1){1'b0}}, 1'b1});

      always @* begin
        presc_d = presc_q + {{(PW-1){1'b0}}, 1'b1};
        if (pulse_edge || tick) begin
          presc_d = {PW{1'b0}};
        end
      end

      // Preload write wins over a pulse edge in the same cycle
      always @* begin
        skip_d = skip_q;
        if (preload_wr_w[ch]) begin
          skip_d = `FTC_SKIP_PULSES;
        end else if (pulse_edge && (skip_q != 2'd0)) begin
          skip_d = skip_q - 2'd1;
        end
      end

      always @(posedge clk_sys_i) begin
        if (rst_i) begin
          presc_q <= {PW{1'b0}};
          skip_q <= 2'd0;
          valid_q <= 1'b1;
          fresh_q <= 1'b0;
          stall_q <= 1'b0;
        end else begin
          presc_q <= presc_d;
          skip_q <= skip_d;
          // Registered copy of the skip test, same cycle as skip_q
          valid_q <= (skip_d == 2'd0);
          // New reading flag: set beats the read that clears it
          if (pulse_edge) begin
            fresh_q <= 1'b1;
          end else if (tach_rd_w[ch]) begin
            fresh_q <= 1'b0;
          end
          // Stall flag: set beats the write-one clear
          if (sat_w[ch]) begin
            stall_q <= 1'b1;
          end else if (stall_clr_w[ch]) begin
            stall_q <= 1'b0;
          end
        end
      end

      ftc_count_core #(
        .CW(CW)
      ) u_core (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pulse_edge_i(pulse_edge),
        .tick_i(tick),
        .preload_i(preload_q[8*ch +: 8]),
        .count_o(tach_w[8*ch +: 8]),
        .sat_o(sat_w[ch])
      );

      assign valid_w[ch] = valid_q;
      assign fresh_w[ch] = fresh_q;
      assign stall_w[ch] = stall_q;
    end
  endgenerate

endmodule

// ===== verif/ftc_fan_model.sv
module ftc_fan_model (
  input wire logic run_i,
  input wire integer half_cyc_i,
  output logic tach_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Offset keeps pin edges away from the clock edge; a stopped fan idles low
  initial begin
    tach_o = 1'b0;
    #13;
    forever begin
      #(half_cyc_i * 50);
      tach_o = run_i ? ~tach_o : 1'b0;
    end
  end
endmodule

// ===== verif/ftc_top_assertions.sv
module ftc_chk (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [7:0] bus_addr_i,
  input wire [7:0] bus_wdata_i,
  input wire bus_wr_i,
  input wire bus_rd_i,
  input wire [7:0] bus_rdata_o,
  input wire fan_one_tach_i,
  input wire fan_two_tach_i,
  input wire [1:0] fan_count_valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  rd_idle_a: assert property (!$past(bus_rd_i) |-> bus_rdata_o == 8'h00)
    else $error("read data not idle");
  rd_unmapped_a: assert property ($past(bus_rd_i) && $past(bus_addr_i) > 8'h07
    |-> bus_rdata_o == 8'h00) else $error("unmapped read not zero");
  cfg_readback_a: assert property ($past(bus_rd_i) && $past(bus_addr_i) == 8'h00
    && $past(bus_wr_i, 3) && $past(bus_addr_i, 3) == 8'h00
    |-> bus_rdata_o == $past(bus_wdata_i, 3)) else $error("config readback wrong");
  spd_readback_a: assert property ($past(bus_rd_i) && $past(bus_addr_i) == 8'h05
    && $past(bus_wr_i, 3) && $past(bus_addr_i, 3) == 8'h05
    |-> bus_rdata_o == ($past(bus_wdata_i, 3) & 8'h80)) else $error("speed readback wrong");
  skip_one_a: assert property (bus_wr_i && bus_addr_i == 8'h03
    |=> !fan_count_valid_o[0]) else $error("fan one still valid");
  skip_two_a: assert property (bus_wr_i && bus_addr_i == 8'h04
    |=> !fan_count_valid_o[1]) else $error("fan two still valid");
  valid_fall_a: assert property ($fell(fan_count_valid_o[0])
    |-> $past(bus_wr_i) && $past(bus_addr_i) == 8'h03) else $error("valid fell alone");
  reset_state_a: assert property ($fell(rst_i) |-> fan_count_valid_o == 2'b11)
    else $error("valid wrong after reset");
  cover property (bus_wr_i && bus_addr_i == 8'h03);
  cover property ($rose(fan_count_valid_o[0]));
  cover property ($past(bus_rd_i) && bus_rdata_o == 8'hff);
endmodule

bind ftc_top ftc_chk chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
  .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
  .bus_rdata_o(bus_rdata_o), .fan_one_tach_i(fan_one_tach_i),
  .fan_two_tach_i(fan_two_tach_i), .fan_count_valid_o(fan_count_valid_o));

// ===== verif/ftc_top_tb.sv
module ftc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic bus_wr_i = 1'b0;
  logic bus_rd_i = 1'b0;
  logic [7:0] bus_addr_i = 8'h00;
  logic [7:0] bus_wdata_i = 8'h00;
  wire [7:0] bus_rdata_o;
  wire [1:0] fan_count_valid_o;
  wire fan_one_tach_i;
  wire fan_two_tach_i;
  logic [1:0] run = 2'b00;
  int half1 = 100;
  int half2 = 100;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [7:0] cfg, s1, s2, pr, rv;
  logic [7:0] msk = 8'hff;
  int p1, p2, k1, k2, tw;
  always #25 clk_sys_i = ~clk_sys_i;
  ftc_top dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_rdata_o(bus_rdata_o), .fan_one_tach_i(fan_one_tach_i),
    .fan_two_tach_i(fan_two_tach_i), .fan_count_valid_o(fan_count_valid_o));
  ftc_fan_model first_fan_speed_control_u (.run_i(run[0]), .half_cyc_i(half1), .tach_o(fan_one_tach_i));
  ftc_fan_model second_fan_speed_control_u (.run_i(run[1]), .half_cyc_i(half2), .tach_o(fan_two_tach_i));
  function automatic int tick(bit b, bit s, bit m, bit [1:0] v);
    return ((64 << {b, s}) >> m) << v;
  endfunction
  function automatic logic [7:0] expc(int pre, int k);
    return (pre + k > 255) ? 8'hff : 8'(pre + k);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    bus_wr_i <= 1'b1;
    bus_addr_i <= a;
    bus_wdata_i <= d;
    @(posedge clk_sys_i);
    bus_wr_i <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    bus_rd_i <= 1'b1;
    bus_addr_i <= a;
    @(posedge clk_sys_i);
    bus_rd_i <= 1'b0;
    #1;
    chk(bus_rdata_o & msk, exp);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Old half period must drain before a new fan period takes hold
  task automatic settle;
    tw = 2 * (half1 > half2 ? 2 * half1 : 2 * half2) + tw + 40;
    repeat (tw) @(posedge clk_sys_i);
    tw = 2 * (half1 > half2 ? half1 : half2);
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    rv = 8'($urandom(8397));
    tw = 200;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rchk(8'h01, 8'h00);
    rchk(8'h02, 8'h00);
    rchk(8'h00, 8'h50);
    wr(8'h01, 8'($urandom));
    rchk(8'h01, 8'h00);
    rchk(8'(8 + $urandom % 248), 8'h00);
    rv = 8'($urandom);
    wr(8'h05, rv);
    rchk(8'h05, rv & 8'h80);
    run = 2'b11;
    for (int i = 0; i < 4; i++) begin
      cfg = {2'(3 - i), 2'(i), 4'($urandom)};
      s1 = (i < 2) ? 8'($urandom) & 8'h80 : 8'h00;
      s2 = (i > 1) ? 8'($urandom) & 8'h80 : 8'h00;
      wr(8'h00, cfg);
      rchk(8'h00, cfg);
      wr(8'h05, s1);
      wr(8'h06, s2);
      rchk(8'h06, s2);
      p1 = tick(cfg[0], s1[7], cfg[2], cfg[5:4]);
      p2 = tick(cfg[1], s2[7], cfg[3], cfg[7:6]);
      k1 = 1 + $urandom % 2;
      k2 = 1 + $urandom % 2;
      // Half a tick of margin keeps edge-to-tick alignment out of the result
      half1 = (k1 * p1 + p1 / 2) / 2;
      half2 = (k2 * p2 + p2 / 2) / 2;
      settle();
      rchk(8'h01, expc(0, k1));
      rchk(8'h02, expc(0, k2));
    end
    pr = 8'($urandom);
    wr(8'h03, pr);
    #1;
    chk({7'h00, fan_count_valid_o[0]}, 8'h00);
    wr(8'h04, pr);
    #1;
    chk({7'h00, fan_count_valid_o[1]}, 8'h00);
    settle();
    chk({6'h00, fan_count_valid_o}, 8'h03);
    rchk(8'h03, pr);
    rchk(8'h01, expc(pr, k1));
    rchk(8'h02, expc(pr, k2));
    wr(8'h03, 8'h00);
    wr(8'h00, 8'h04);
    run[0] = 1'b0;
    repeat (255 * 32 + tw) @(posedge clk_sys_i);
    rchk(8'h01, 8'hff);
    // Fan two stall bit depends on its preload and its fresh bit on pulse timing, so both are masked
    msk = 8'hd7;
    rchk(8'h07, 8'h12);
    wr(8'h07, 8'h10);
    rchk(8'h07, 8'h12);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    msk = 8'hff;
    rchk(8'h01, 8'h00);
    msk = 8'hd7;
    rchk(8'h07, 8'h03);
    tally_and_finish();
  end
endmodule
